// [hdl/i2cms_master.sv]
// i2c master transaction sequencer: data and control state, byte sequencing, link crossing
`timescale 1ns/100ps
`include "i2cms_defines.svh"
module i2cms_master #(
  parameter int QUARTER_CYCLES = `I2CMS_QUARTER_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       linkClk,
  input  wire logic       interfaceEnable,
  input  wire logic       transmitIrqEnable,
  input  wire logic       startSet,
  input  wire logic       stopSet,
  input  wire logic       nakSet,
  input  wire logic       flushSet,
  input  wire logic       dataWrite,
  input  wire logic [7:0] dataWriteByte,
  input  wire logic       dataRead,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic      [7:0] dataReadByte,
  output logic            startPending,
  output logic            stopPending,
  output logic            nakPending,
  output logic            txHoldingEmpty,
  output logic            rxFull,
  output logic            ackFlag,
  output logic            tenBitAddrFlag,
  output logic            readDir,
  output logic            addrState,
  output logic            dataShiftState,
  output logic            nackIrqFlag,
  output logic            txIrq,
  output logic            sclOut,
  output logic            sclOe,
  output logic            sdaOut,
  output logic            sdaOe
);

  i2cms_pkg::i2cms_seq_state_t state_q, state_d;
  i2cms_pkg::i2cms_cmd_t       cmd_q, cmd_d;
  logic [7:0] data_q, data_d;
  logic [7:0] shift_q, shift_d;
  logic       req_q, req_d;
  logic       ackBit_q, ackBit_d;
  logic       start_q, start_d;
  logic       stop_q, stop_d;
  logic       nak_q, nak_d;
  logic       txEmpty_q, txEmpty_d;
  logic       rxFull_q, rxFull_d;
  logic       ackFlag_q, ackFlag_d;
  logic       tenBit_q, tenBit_d;
  logic       readDir_q, readDir_d;
  logic       addrState_q, addrState_d;
  logic       dataShift_q, dataShift_d;
  logic       nackIrq_q, nackIrq_d;
  logic       txIrq_q, txIrq_d;
  logic       shiftFull_q, shiftFull_d;
  logic       firstBitSeen_q, firstBitSeen_d;
  logic       reading_q, reading_d;
  logic       forceStop_q, forceStop_d;
  logic       tglPrev_q, tglPrev_d;

  logic       linkRst_n;
  logic       reqLink;
  logic       sclLink;
  logic       sdaLink;
  logic       doneLink;
  logic       tglLink;
  logic       doneSys;
  logic       tglSys;
  logic [7:0] rxByte;
  logic       firstBitEvt;
  logic       ready;
  logic       nackSetEvt;
  logic       inhibit;

  // reset, request and pin levels into the link domain
  i2cms_sync #(.WIDTH(1)) u_rst_sync (
    .clk     (linkClk),
    .dataIn  (rst_n),
    .dataOut (linkRst_n)
  );
  i2cms_sync #(.WIDTH(1)) u_req_sync (
    .clk     (linkClk),
    .dataIn  (req_q),
    .dataOut (reqLink)
  );
  i2cms_sync #(.WIDTH(2)) u_pin_sync (
    .clk     (linkClk),
    .dataIn  ({sclIn, sdaIn}),
    .dataOut ({sclLink, sdaLink})
  );

  // done level and first-bit toggle back into the system domain
  i2cms_sync #(.WIDTH(2)) u_back_sync (
    .clk     (sys_clk),
    .dataIn  ({doneLink, tglLink}),
    .dataOut ({doneSys, tglSys})
  );

  // bus engine; cmd, shift and ack bit stay still while the request is up
  i2cms_link_engine #(.QUARTER_CYCLES(QUARTER_CYCLES)) u_link (
    .linkClk     (linkClk),
    .linkRst_n   (linkRst_n),
    .cmdReq      (reqLink),
    .cmd         (cmd_q),
    .txByte      (shift_q),
    .ackBit      (ackBit_q),
    .sclIn       (sclLink),
    .sdaIn       (sdaLink),
    .cmdDone     (doneLink),
    .rxByte      (rxByte),
    .firstBitTgl (tglLink),
    .sclOut      (sclOut),
    .sclOe       (sclOe),
    .sdaOut      (sdaOut),
    .sdaOe       (sdaOe)
  );

  // transaction sequencer and software side effects
  always_comb begin
    state_d = state_q; cmd_d = cmd_q; data_d = data_q; shift_d = shift_q; req_d = req_q;
    ackBit_d = ackBit_q; start_d = start_q; stop_d = stop_q; nak_d = nak_q;
    txEmpty_d = txEmpty_q; rxFull_d = rxFull_q; ackFlag_d = ackFlag_q; tenBit_d = tenBit_q;
    readDir_d = readDir_q; addrState_d = addrState_q; dataShift_d = dataShift_q;
    nackIrq_d = nackIrq_q; shiftFull_d = shiftFull_q; firstBitSeen_d = firstBitSeen_q;
    reading_d = reading_q; forceStop_d = forceStop_q;
    tglPrev_d   = tglSys;
    firstBitEvt = tglSys ^ tglPrev_q;
    ready       = !req_q && !doneSys;
    nackSetEvt  = 1'b0;
    // reading the data clears the receive request
    if (dataRead) rxFull_d = 1'b0;
    case (state_q)
      i2cms_pkg::S_IDLE: begin
        // start only once a byte is waiting
        if (interfaceEnable && start_q && !txEmpty_q && ready) begin
          req_d   = 1'b1;
          cmd_d   = i2cms_pkg::CMD_START;
          state_d = i2cms_pkg::S_BUSY;
        end
      end
      i2cms_pkg::S_BUSY: begin
        if (req_q && doneSys) begin
          req_d   = 1'b0;
          state_d = i2cms_pkg::S_DECIDE;
          case (cmd_q)
            i2cms_pkg::CMD_START: begin
              start_d = 1'b0;
              // data register moves into the shift register
              shift_d        = data_q;
              txEmpty_d      = 1'b1;
              shiftFull_d    = 1'b1;
              firstBitSeen_d = 1'b0;
              addrState_d    = 1'b1;
              dataShift_d    = 1'b0;
              reading_d      = 1'b0;
              readDir_d = data_q[`I2CMS_DIR_BIT];
              tenBit_d = (data_q[`I2CMS_PREFIX_MSB:`I2CMS_PREFIX_LSB] == `I2CMS_TEN_BIT_PREFIX);
            end
            i2cms_pkg::CMD_WRITE: begin
              shiftFull_d = 1'b0;
              // low in the ack slot means acknowledged
              ackFlag_d = !rxByte[0];
              if (addrState_q) begin
                // cleared once the first address byte is out
                addrState_d = 1'b0; tenBit_d = 1'b0;
                reading_d = readDir_q && !rxByte[0];
              end
              if (rxByte[0]) begin
                forceStop_d = 1'b1;
                nackSetEvt  = !(start_q || stop_q);
              end
            end
            i2cms_pkg::CMD_READ: begin
              data_d   = rxByte;
              rxFull_d = 1'b1;
              state_d  = i2cms_pkg::S_RXWAIT;
            end
            i2cms_pkg::CMD_ACK: begin
              ackFlag_d = !ackBit_q;
              if (ackBit_q) begin
                nak_d = 1'b0; reading_d = 1'b0; dataShift_d = 1'b0;
                // nak sent, wait for software unless stop is pending
                if (!stop_q) begin
                  nackSetEvt = !start_q;
                  state_d    = i2cms_pkg::S_NAKWAIT;
                end
              end
            end
            default: begin
              stop_d = 1'b0; forceStop_d = 1'b0; reading_d = 1'b0; dataShift_d = 1'b0;
              state_d = i2cms_pkg::S_IDLE;
            end
          endcase
        end
      end
      i2cms_pkg::S_DECIDE: begin
        if (!interfaceEnable) begin
          if (ready) begin
            state_d = i2cms_pkg::S_IDLE; reading_d = 1'b0; addrState_d = 1'b0;
            dataShift_d = 1'b0; shiftFull_d = 1'b0; forceStop_d = 1'b0;
          end
        end else if (ready) begin
          state_d = i2cms_pkg::S_BUSY;
          req_d   = 1'b1;
          // byte already finished when we get here
          if (forceStop_q || stop_q) begin
            cmd_d = i2cms_pkg::CMD_STOP; forceStop_d = 1'b0;
          end else if (reading_q) begin
            cmd_d = i2cms_pkg::CMD_READ; dataShift_d = 1'b1;
          // restart after the byte is acknowledged
          end else if (start_q && !txEmpty_q) begin
            cmd_d = i2cms_pkg::CMD_START;
          end else if (shiftFull_q) begin
            // the loaded byte goes on the wire now; tx irq then waits only for its first bit unless the address has the read bit set
            cmd_d       = i2cms_pkg::CMD_WRITE;
            shiftFull_d = 1'b0;
          end else if (txEmpty_q) begin
            cmd_d = i2cms_pkg::CMD_STOP;
          end else begin
            cmd_d = i2cms_pkg::CMD_WRITE; shift_d = data_q; txEmpty_d = 1'b1;
            firstBitSeen_d = 1'b0; dataShift_d = 1'b1;
          end
        end
      end
      i2cms_pkg::S_RXWAIT: begin
        // a pending stop also ends the read with nak
        if (!rxFull_q && ready) begin
          req_d = 1'b1; cmd_d = i2cms_pkg::CMD_ACK; ackBit_d = nak_q || stop_q;
          state_d = i2cms_pkg::S_BUSY;
        end
      end
      default: begin
        // hold until software asks for stop or restart
        if (!interfaceEnable) begin
          state_d = i2cms_pkg::S_IDLE;
        end else if (stop_q || (start_q && !txEmpty_q)) begin
          state_d = i2cms_pkg::S_DECIDE;
        end
      end
    endcase
    // software sets come after the hardware clears so they are not lost
    if (startSet) start_d = 1'b1;
    if (stopSet) stop_d = 1'b1;
    if (nakSet) nak_d = 1'b1;
    if (dataWrite) begin
      data_d    = dataWriteByte;
      txEmpty_d = 1'b0;
    end
    if (flushSet) begin
      data_d    = `I2CMS_DATA_RESET;
      txEmpty_d = 1'b1;
    end
    if (!interfaceEnable) begin
      start_d = 1'b0;
      stop_d  = 1'b0;
      nak_d   = 1'b0;
    end
    // only start or stop clears the nak flag; a new nak wins
    if (startSet || stopSet) nackIrq_d = 1'b0;
    if (nackSetEvt) nackIrq_d = 1'b1;
    if (firstBitEvt) firstBitSeen_d = 1'b1;
  end

  // transmit request gating while the held byte is not yet on the wire
  always_comb begin
    inhibit = shiftFull_q || reading_q || (addrState_q && readDir_q) ||
              (state_q == i2cms_pkg::S_BUSY && cmd_q == i2cms_pkg::CMD_WRITE && !firstBitSeen_q);
    // empty holding register requests data when enabled
    txIrq_d = interfaceEnable && transmitIrqEnable && txEmpty_q && !inhibit;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= i2cms_pkg::S_IDLE; cmd_q <= i2cms_pkg::CMD_START; data_q <= `I2CMS_DATA_RESET;
      shift_q <= `I2CMS_DATA_RESET; req_q <= 1'b0; ackBit_q <= 1'b0; start_q <= 1'b0;
      stop_q <= 1'b0; nak_q <= 1'b0; txEmpty_q <= `I2CMS_HOLD_EMPTY_RESET; rxFull_q <= 1'b0;
      ackFlag_q <= 1'b0; tenBit_q <= 1'b0; readDir_q <= 1'b0; addrState_q <= 1'b0;
      dataShift_q <= 1'b0; nackIrq_q <= 1'b0; txIrq_q <= 1'b0; shiftFull_q <= 1'b0;
      firstBitSeen_q <= 1'b0; reading_q <= 1'b0; forceStop_q <= 1'b0; tglPrev_q <= 1'b0;
    end else begin
      state_q <= state_d; cmd_q <= cmd_d; data_q <= data_d; shift_q <= shift_d; req_q <= req_d;
      ackBit_q <= ackBit_d; start_q <= start_d; stop_q <= stop_d; nak_q <= nak_d;
      txEmpty_q <= txEmpty_d; rxFull_q <= rxFull_d; ackFlag_q <= ackFlag_d; tenBit_q <= tenBit_d;
      readDir_q <= readDir_d; addrState_q <= addrState_d; dataShift_q <= dataShift_d;
      nackIrq_q <= nackIrq_d; txIrq_q <= txIrq_d; shiftFull_q <= shiftFull_d;
      firstBitSeen_q <= firstBitSeen_d; reading_q <= reading_d; forceStop_q <= forceStop_d;
      tglPrev_q <= tglPrev_d;
    end
  end

  // status and request outputs straight from registers
  assign dataReadByte   = data_q;
  assign startPending   = start_q;
  assign stopPending    = stop_q;
  assign nakPending     = nak_q;
  assign txHoldingEmpty = txEmpty_q;
  assign rxFull         = rxFull_q;
  assign ackFlag        = ackFlag_q;
  assign tenBitAddrFlag = tenBit_q;
  assign readDir        = readDir_q;
  assign addrState      = addrState_q;
  assign dataShiftState = dataShift_q;
  assign nackIrqFlag    = nackIrq_q;
  assign txIrq          = txIrq_q;

endmodule

// [include/i2cms_defines.svh]
// timing counts, field positions and reset values of the i2c master sequencer
`ifndef I2CMS_DEFINES_SVH
`define I2CMS_DEFINES_SVH

// first address byte layout
`define I2CMS_TEN_BIT_PREFIX   5'h1E
`define I2CMS_PREFIX_MSB       7
`define I2CMS_PREFIX_LSB       3
`define I2CMS_DIR_BIT          0

// reset values
`define I2CMS_DATA_RESET       8'h00
`define I2CMS_HOLD_EMPTY_RESET 1'b1

// bit timing: one quarter of an scl period, in ns and in link clock cycles
`define I2CMS_QUARTER_NS       625
`define I2CMS_LINK_PERIOD_NS   15
`define I2CMS_QUARTER_CYCLES   ((`I2CMS_QUARTER_NS + `I2CMS_LINK_PERIOD_NS - 1) / `I2CMS_LINK_PERIOD_NS)

// bits moved on the wire per command
`define I2CMS_WRITE_BITS       4'h9
`define I2CMS_READ_BITS        4'h8
`define I2CMS_ACK_BITS         4'h1

`endif

// [include/i2cms_pkg.sv]
// types shared by the i2c master sequencer and its link engine
package i2cms_pkg;

  // bus operations handed from the sequencer to the link engine
  typedef enum logic [2:0] {CMD_START, CMD_STOP, CMD_WRITE, CMD_READ, CMD_ACK} i2cms_cmd_t;

  // sequencer states on the system clock
  typedef enum logic [2:0] {S_IDLE, S_BUSY, S_DECIDE, S_RXWAIT, S_NAKWAIT} i2cms_seq_state_t;

  // link engine states on the link clock
  typedef enum logic [2:0] {E_IDLE, E_START, E_STOP, E_BITS, E_DONE} i2cms_link_state_t;

endpackage

// [hdl/i2cms_sync.sv]
// two-flop synchroniser for levels entering a clock domain
`timescale 1ns/100ps
module i2cms_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] dataIn,
  output logic      [WIDTH-1:0] dataOut
);

  logic [WIDTH-1:0] stage_q;
  logic [WIDTH-1:0] stage_d;
  logic [WIDTH-1:0] out_d;

  // first stage feeds only the second stage
  always_comb begin
    stage_d = dataIn;
    out_d   = stage_q;
  end

  always_ff @(posedge clk) begin
    stage_q <= stage_d;
    dataOut <= out_d;
  end

endmodule

// [hdl/i2cms_link_engine.sv]
// bit-level scl/sda engine on the link clock: start, stop, byte and acknowledge slots
`timescale 1ns/100ps
`include "i2cms_defines.svh"
module i2cms_link_engine #(
  parameter int QUARTER_CYCLES = `I2CMS_QUARTER_CYCLES
) (
  input  wire logic                 linkClk,
  input  wire logic                 linkRst_n,
  input  wire logic                 cmdReq,
  input  wire i2cms_pkg::i2cms_cmd_t cmd,
  input  wire logic [7:0]           txByte,
  input  wire logic                 ackBit,
  input  wire logic                 sclIn,
  input  wire logic                 sdaIn,
  output logic                      cmdDone,
  output logic [7:0]                rxByte,
  output logic                      firstBitTgl,
  output logic                      sclOut,
  output logic                      sclOe,
  output logic                      sdaOut,
  output logic                      sdaOe
);

  localparam logic [15:0] QCNT_LAST = 16'(QUARTER_CYCLES - 1);

  i2cms_pkg::i2cms_link_state_t state_q, state_d;
  logic [1:0]  phase_q, phase_d;
  logic [15:0] qcnt_q, qcnt_d;
  logic [3:0]  bitCnt_q, bitCnt_d;
  logic [7:0]  shift_q, shift_d;
  logic        sclOe_q, sclOe_d, sdaOe_q, sdaOe_d, done_q, done_d, tgl_q, tgl_d;
  logic [3:0]  nBits;
  logic        bitVal;

  // phase sequencer: each phase lasts one quarter of an scl period
  always_comb begin
    state_d = state_q; phase_d = phase_q; qcnt_d = qcnt_q; bitCnt_d = bitCnt_q;
    shift_d = shift_q; sclOe_d = sclOe_q; sdaOe_d = sdaOe_q; done_d = done_q; tgl_d = tgl_q;
    nBits  = (cmd == i2cms_pkg::CMD_WRITE) ? `I2CMS_WRITE_BITS :
             (cmd == i2cms_pkg::CMD_READ) ? `I2CMS_READ_BITS : `I2CMS_ACK_BITS;
    bitVal = (cmd == i2cms_pkg::CMD_WRITE && bitCnt_q < 4'h8) ? shift_q[7] :
             (cmd == i2cms_pkg::CMD_ACK) ? ackBit : 1'b1;
    case (state_q)
      i2cms_pkg::E_IDLE: begin
        qcnt_d = 16'h0000; phase_d = 2'h0; bitCnt_d = 4'h0;
        if (cmdReq) begin
          shift_d = txByte;
          state_d = (cmd == i2cms_pkg::CMD_START) ? i2cms_pkg::E_START :
                    (cmd == i2cms_pkg::CMD_STOP) ? i2cms_pkg::E_STOP : i2cms_pkg::E_BITS;
        end
      end
      i2cms_pkg::E_DONE: begin
        done_d = 1'b1;
        if (!cmdReq) begin
          done_d  = 1'b0;
          state_d = i2cms_pkg::E_IDLE;
        end
      end
      default: begin
        // lines are only pulled low or released
        case ({state_q == i2cms_pkg::E_BITS, state_q == i2cms_pkg::E_STOP, phase_q})
          4'h8: sdaOe_d = !bitVal;    // sda moves mid scl low
          4'h4: sdaOe_d = 1'b1;
          4'h6: sdaOe_d = 1'b0;       // stop: sda rises while scl high
          4'h0: sdaOe_d = 1'b0;
          4'h2: sdaOe_d = 1'b1;       // start: sda falls while scl high
          4'h3: sclOe_d = 1'b1;
          4'hB: sclOe_d = 1'b1;
          default: if (phase_q == 2'h1) sclOe_d = 1'b0;
        endcase
        // hold the phase while a slave stretches scl
        if (phase_q == 2'h1 && !sclIn) begin
          qcnt_d = 16'h0000;
        end else if (qcnt_q == QCNT_LAST) begin
          qcnt_d  = 16'h0000;
          phase_d = phase_q + 2'h1;
          if (state_q == i2cms_pkg::E_BITS && phase_q == 2'h1) shift_d = {shift_q[6:0], sdaIn};
          if (phase_q == 2'h3) begin
            if (state_q != i2cms_pkg::E_BITS || bitCnt_q == nBits - 4'h1) state_d = i2cms_pkg::E_DONE;
            bitCnt_d = bitCnt_q + 4'h1;
            if (cmd == i2cms_pkg::CMD_WRITE && bitCnt_q == 4'h0) tgl_d = !tgl_q;
          end
        end else begin
          qcnt_d = qcnt_q + 16'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge linkClk) begin
    if (!linkRst_n) begin
      state_q <= i2cms_pkg::E_IDLE; phase_q <= 2'h0; qcnt_q <= 16'h0000; bitCnt_q <= 4'h0;
      shift_q <= 8'h00; sclOe_q <= 1'b0; sdaOe_q <= 1'b0; done_q <= 1'b0; tgl_q <= 1'b0;
    end else begin
      state_q <= state_d; phase_q <= phase_d; qcnt_q <= qcnt_d; bitCnt_q <= bitCnt_d;
      shift_q <= shift_d; sclOe_q <= sclOe_d; sdaOe_q <= sdaOe_d; done_q <= done_d; tgl_q <= tgl_d;
    end
  end

  // pin data is always low; the enables decide whether the line is pulled
  always_ff @(posedge linkClk) begin
    sclOut <= 1'b0;
    sdaOut <= 1'b0;
  end

  assign cmdDone     = done_q;
  assign rxByte      = shift_q;
  assign firstBitTgl = tgl_q;
  assign sclOe       = sclOe_q;
  assign sdaOe       = sdaOe_q;

endmodule

// [verification/i2cms_checker.sv]
// assertions on the i2c master sequencer top ports
`timescale 1ns/100ps
module i2cms_checker #(
  parameter int QUARTER_CYCLES = 3
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic linkClk,
  input wire logic interfaceEnable,
  input wire logic transmitIrqEnable,
  input wire logic startSet,
  input wire logic stopSet,
  input wire logic dataWrite,
  input wire logic startPending,
  input wire logic stopPending,
  input wire logic txHoldingEmpty,
  input wire logic nackIrqFlag,
  input wire logic txIrq,
  input wire logic sclIn,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaOut,
  input wire logic sdaOe
);
  // pins: pulled low only, paused while the slave holds scl, start only on request
  scl_low_only_a: assert property (@(posedge linkClk) disable iff (!rst_n) sclOe |-> !sclOut)
    else $error("scl driven high");
  sda_low_only_a: assert property (@(posedge linkClk) disable iff (!rst_n) sdaOe |-> !sdaOut)
    else $error("sda driven high");
  stretch_hold_a: assert property (@(posedge linkClk) disable iff (!rst_n) !sclOe && !sclIn |=> !sclOe)
    else $error("scl pulled while held by slave");
  start_on_req_a: assert property (@(posedge linkClk) disable iff (!rst_n) $rose(sdaOe) && !sclOe |-> startPending)
    else $error("start without request");
  // software side: request clearing, nak flag, transmit interrupt
  req_disable_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !interfaceEnable && !startSet && !stopSet |=> !startPending && !stopPending)
    else $error("request kept while disabled");
  nak_irq_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    nackIrqFlag && !startSet && !stopSet |=> nackIrqFlag)
    else $error("nak flag cleared without request");
  txirq_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n) !transmitIrqEnable |=> !txIrq)
    else $error("tx irq while disabled");
  write_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n) dataWrite |=> !txHoldingEmpty ##1 !txIrq)
    else $error("data write kept tx irq");
  cover property (@(posedge sys_clk) $rose(nackIrqFlag));
  cover property (@(posedge sys_clk) $fell(startPending));
  cover property (@(posedge linkClk) !sclOe && !sclIn);
endmodule

bind i2cms_master i2cms_checker #(.QUARTER_CYCLES(QUARTER_CYCLES)) chk (.*);

// [verification/i2cms_slave_model.sv]
// behavioural i2c slave: acks, read data, clock stretching, byte log
`timescale 1ns/100ps
module i2cms_slave_model (
  input  wire logic       sclLine,
  input  wire logic       sdaLine,
  input  wire logic       nakWrite,
  input  wire logic       stretch,
  input  wire logic [7:0] readData,
  output logic            sclHold,
  output logic            sdaHold
);
  logic [7:0] shift, got[$];
  logic       rd = 1'b0, first = 1'b0, ackSeen = 1'b0;
  int         cnt = 0, nStart = 0, nStop = 0;
  initial sclHold = 1'b0;
  initial sdaHold = 1'b0;
  // start or stop condition: sda moves while scl is high
  always @(sdaLine) if (sclLine === 1'b1) begin
    if (sdaLine === 1'b0) begin
      cnt = -1;
      first = 1'b1;
      nStart++;
    end else begin
      sdaHold = 1'b0;
      nStop++;
    end
  end
  // sample bits and the master's ack slot
  always @(posedge sclLine) begin
    if (cnt < 8) shift = {shift[6:0], sdaLine};
    if (cnt == 8) ackSeen = !sdaLine;
  end
  // drive sda early in the low phase
  always @(negedge sclLine) begin
    cnt++;
    #20;
    if (cnt == 9) begin
      cnt = 0;
      sdaHold = rd && (first || ackSeen) && !readData[7];
      first = 1'b0;
      // hold scl low after a byte
      if (stretch) begin
        sclHold = 1'b1;
        #300 sclHold = 1'b0;
      end
    end else if (cnt == 8) begin
      if (first || !rd) begin
        got.push_back(shift);
        if (first) rd = shift[0];
        sdaHold = !nakWrite;
      end else sdaHold = 1'b0;
    end else if (rd && !first && cnt > 0) sdaHold = !readData[7 - cnt];
  end
endmodule

// [verification/tb_i2c_master_transaction_sequencer.sv]
// self-checking bench for the i2c master sequencer
`timescale 1ns/100ps
module tb_i2c_master_transaction_sequencer;
  logic sys_clk, rst_n, linkClk, interfaceEnable, transmitIrqEnable, startSet, stopSet, nakSet, flushSet;
  logic dataWrite, dataRead, sclIn, sdaIn, startPending, stopPending, nakPending, txHoldingEmpty, rxFull;
  logic ackFlag, tenBitAddrFlag, readDir, addrState, dataShiftState, nackIrqFlag, txIrq, sclOut, sclOe;
  logic sdaOut, sdaOe, sclHold, sdaHold, nakWrite, stretch;
  logic [7:0] dataWriteByte, dataReadByte, readData;
  int errors = 0, num_checks = 0, cycles = 0, s0, s1;
  // write rows: address, data, slave stretches, no data byte
  typedef struct {logic [7:0] a, d; logic st, nd;} i2cms_row_t;
  i2cms_row_t rows[4] = '{'{8'hA4, 8'h5A, 1'b0, 1'b0}, '{8'h3C, 8'hC3, 1'b1, 1'b0},
                          '{8'hFE, 8'hFF, 1'b1, 1'b0}, '{8'h52, 8'h00, 1'b0, 1'b1}};
  i2cms_master #(.QUARTER_CYCLES(3)) dut (.*);
  i2cms_slave_model slv (.sclLine(sclIn), .sdaLine(sdaIn), .nakWrite(nakWrite), .stretch(stretch),
                         .readData(readData), .sclHold(sclHold), .sdaHold(sdaHold));
  // open-drain lines with pull-ups
  assign sclIn = !(sclOe || sclHold);
  assign sdaIn = !(sdaOe || sdaHold);
  // clocks: system 8 ns, link 15 ns with its own phase
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    linkClk = 1'b0;
    #3.3;
    forever #7.5 linkClk = ~linkClk;
  end
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // cut a hung run short
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic chk1(string n, logic e, logic g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic clk(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    clk(1);
    s = 1'b0;
  endtask
  task automatic wr(logic [7:0] b);
    dataWriteByte = b;
    pulse(dataWrite);
    clk(3);
  endtask
  task automatic waitFor(ref logic s, input logic v);
    int n = 0;
    while (s !== v && n < 5000) begin
      clk(1);
      n++;
    end
    chk1("wait", v, s);
  endtask
  task automatic waitStop;
    int n = 0;
    while (slv.nStop == s0 && n < 5000) begin
      clk(1);
      n++;
    end
    clk(10);
    chk1("stop", 1'b1, slv.nStop == s0 + 1);
    waitFor(stopPending, 1'b0);
  endtask
  initial begin
    {rst_n, startSet, stopSet, nakSet, flushSet, dataWrite, dataRead, nakWrite, stretch} = 9'h000;
    interfaceEnable = 1'b1;
    transmitIrqEnable = 1'b1;
    dataWriteByte = 8'h00;
    readData = 8'h96;
    clk(16);
    rst_n = 1'b1;
    clk(2);
    // ordinary 7-bit writes
    foreach (rows[i]) begin
      stretch = rows[i].st;
      s0 = slv.nStop;
      wr(rows[i].a);
      pulse(startSet);
      waitFor(txIrq, 1'b1);
      chk1("startPend", 1'b0, startPending);
      if (!rows[i].nd) begin
        wr(rows[i].d);
        waitFor(txIrq, 1'b1);
        pulse(stopSet);
      end
      waitStop();
      chk1("ackFlag", 1'b1, ackFlag);
      chk8("lastByte", rows[i].nd ? rows[i].a : rows[i].d, slv.got[$]);
    end
    // slave refuses the address, byte flushed, then start request and disable
    nakWrite = 1'b1;
    s0 = slv.nStop;
    wr(8'hA4);
    pulse(startSet);
    waitFor(txIrq, 1'b1);
    wr(8'h11);
    waitStop();
    chk1("nakIrq", 1'b1, nackIrqFlag);
    pulse(flushSet);
    chk1("holdEmpty", 1'b1, txHoldingEmpty);
    pulse(startSet);
    chk1("nakIrq", 1'b0, nackIrqFlag);
    interfaceEnable = 1'b0;
    clk(2);
    chk1("startPend", 1'b0, startPending);
    interfaceEnable = 1'b1;
    nakWrite = 1'b0;
    // 7-bit read of one byte answered by nak
    s0 = slv.nStop;
    wr(8'hA5);
    pulse(startSet);
    pulse(nakSet);
    chk1("nakPend", 1'b1, nakPending);
    waitFor(rxFull, 1'b1);
    chk8("rdByte", 8'h96, dataReadByte);
    pulse(dataRead);
    chk1("rxFull", 1'b0, rxFull);
    waitFor(nackIrqFlag, 1'b1);
    chk1("nakPend", 1'b0, nakPending);
    chk1("slvAck", 1'b0, slv.ackSeen);
    pulse(stopSet);
    chk1("nakIrq", 1'b0, nackIrqFlag);
    waitStop();
    // 10-bit read with repeated start, stop requested at the end
    readData = 8'h3C;
    s0 = slv.nStop;
    s1 = slv.nStart;
    wr(8'hF2);
    pulse(startSet);
    waitFor(txIrq, 1'b1);
    chk1("tenBit", 1'b1, tenBitAddrFlag);
    chk1("addrState", 1'b1, addrState);
    wr(8'h34);
    waitFor(txIrq, 1'b1);
    pulse(startSet);
    wr(8'hF3);
    waitFor(rxFull, 1'b1);
    chk1("tenBit", 1'b0, tenBitAddrFlag);
    chk1("readDir", 1'b1, readDir);
    chk1("dataShift", 1'b1, dataShiftState);
    pulse(stopSet);
    pulse(dataRead);
    waitStop();
    chk1("slvAck", 1'b0, slv.ackSeen);
    chk8("rdByte", 8'h3C, dataReadByte);
    chk8("reAddr", 8'hF3, slv.got[$]);
    chk8("lowAddr", 8'h34, slv.got[$-1]);
    chk1("restart", 1'b1, slv.nStart == s1 + 2);
    // reset in mid-run
    rst_n = 1'b0;
    clk(8);
    rst_n = 1'b1;
    clk(2);
    chk8("status", 8'h80, {txHoldingEmpty, rxFull, ackFlag, tenBitAddrFlag,
                           readDir, addrState, dataShiftState, nackIrqFlag});
    chk8("data", 8'h00, dataReadByte);
    chk1("txIrq", 1'b1, txIrq);
    transmitIrqEnable = 1'b0;
    clk(2);
    chk1("txIrqOff", 1'b0, txIrq);
    wrap_up();
  end
endmodule
